// *** rtl/amc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "amc_params.svh"

module amc_ctrl
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   input  wire logic                 req_i,
   input  wire logic                 we_i,
   input  wire logic                 cs_ctrl_i,
   input  wire logic [`AMC_AW-1:0]   addr_i,
   input  wire logic [`AMC_DW-1:0]   wdata_i,
   input  wire logic [`AMC_BW-1:0]   be_i,
   output var  logic                 ready_o,
   output var  logic                 rvalid_o,
   output var  logic [`AMC_DW-1:0]   rdata_o,
   output var  logic                 wdone_o,
   output var  logic [`AMC_AW-1:0]   mem_addr_o,
   output var  logic                 mem_ce_n_o,
   output var  logic                 mem_we_n_o,
   output var  logic                 mem_oe_n_o,
   output var  logic [`AMC_BW-1:0]   byte_lane_select_n_o,
   output var  logic [`AMC_DW-1:0]   mem_dq_o,
   output var  logic                 mem_dq_oe_o,
   input  wire logic [`AMC_DW-1:0]   mem_dq_i
);

   amc_pkg::amc_state_t state_q;
   amc_pkg::amc_state_t state_d;
   logic [`AMC_CW-1:0]  cnt_q;
   logic [`AMC_CW-1:0]  cnt_d;
   logic                csm_q;
   logic                csm_d;
   logic                ready_d;
   logic                rvalid_d;
   logic [`AMC_DW-1:0]  rdata_d;
   logic                wdone_d;
   logic [`AMC_AW-1:0]  addr_d;
   logic                ce_n_d;
   logic                we_n_d;
   logic                oe_n_d;
   logic [`AMC_BW-1:0]  bls_d;
   logic [`AMC_DW-1:0]  dq_d;
   logic                dq_oe_d;
   logic [`AMC_DW-1:0]  dq_sync;

   // ***********************************************
   // read data synchroniser
   // ***********************************************
   amc_sync u_sync
   (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .d_i     (mem_dq_i),
      .q_o     (dq_sync)
   );

   // ***********************************************
   // next state and pin values
   // ***********************************************
   always_comb
   begin
      state_d  = state_q;
      cnt_d    = cnt_q + `AMC_CNT_ONE;
      csm_d    = csm_q;
      rvalid_d = 1'b0;
      rdata_d  = rdata_o;
      wdone_d  = 1'b0;
      addr_d   = mem_addr_o;
      ce_n_d   = mem_ce_n_o;
      we_n_d   = mem_we_n_o;
      oe_n_d   = mem_oe_n_o;
      bls_d    = byte_lane_select_n_o;
      dq_d     = mem_dq_o;
      dq_oe_d  = mem_dq_oe_o;
      case (state_q)
         amc_pkg::AMC_ST_IDLE:
         begin
            cnt_d = `AMC_CNT_RST;
            if (req_i && ready_o)
            begin
               addr_d = addr_i;
               bls_d  = ~be_i;
               if (we_i)
               begin
                  state_d = amc_pkg::AMC_ST_SETUP;
                  csm_d   = cs_ctrl_i;
                  dq_d    = wdata_i;
                  dq_oe_d = 1'b1;
                  if (cs_ctrl_i)
                  begin
                     we_n_d = 1'b0;
                  end
                  else
                  begin
                     ce_n_d = 1'b0;
                  end
               end
               else
               begin
                  state_d = amc_pkg::AMC_ST_RACC;
                  ce_n_d  = 1'b0;
                  oe_n_d  = 1'b0;
                  we_n_d  = 1'b1;
               end
            end
         end
         amc_pkg::AMC_ST_SETUP:
         begin
            state_d = amc_pkg::AMC_ST_STROBE;
            cnt_d   = `AMC_CNT_RST;
            if (csm_q)
            begin
               ce_n_d = 1'b0;
            end
            else
            begin
               we_n_d = 1'b0;
            end
         end
         amc_pkg::AMC_ST_STROBE:
         begin
            if (cnt_q == `AMC_CW'(`AMC_WP_CYC - 1))
            begin
               state_d = amc_pkg::AMC_ST_RECOV;
               cnt_d   = `AMC_CNT_RST;
               if (csm_q)
               begin
                  ce_n_d = 1'b1;
               end
               else
               begin
                  we_n_d = 1'b1;
               end
            end
         end
         amc_pkg::AMC_ST_RECOV:
         begin
            if (cnt_q == `AMC_CW'(`AMC_WR_CYC - 1))
            begin
               state_d = amc_pkg::AMC_ST_IDLE;
               ce_n_d  = 1'b1;
               we_n_d  = 1'b1;
               bls_d   = `AMC_BLS_IDLE;
               dq_oe_d = 1'b0;
               wdone_d = 1'b1;
            end
         end
         amc_pkg::AMC_ST_RACC:
         begin
            if (cnt_q == `AMC_CW'(`AMC_RD_CYC + `AMC_SYNC_STAGES - 1))
            begin
               state_d  = amc_pkg::AMC_ST_GAP;
               cnt_d    = `AMC_CNT_RST;
               rdata_d  = dq_sync;
               rvalid_d = 1'b1;
               ce_n_d   = 1'b1;
               oe_n_d   = 1'b1;
               bls_d    = `AMC_BLS_IDLE;
            end
         end
         amc_pkg::AMC_ST_GAP:
         begin
            if (cnt_q == `AMC_CW'(`AMC_HZ_CYC - 1))
            begin
               state_d = amc_pkg::AMC_ST_IDLE;
            end
         end
         default:
         begin
            state_d = amc_pkg::AMC_ST_IDLE;
            ce_n_d  = 1'b1;
            we_n_d  = 1'b1;
            oe_n_d  = 1'b1;
            bls_d   = `AMC_BLS_IDLE;
            dq_oe_d = 1'b0;
         end
      endcase
      ready_d = (state_d == amc_pkg::AMC_ST_IDLE) && !(req_i && ready_o && state_q == amc_pkg::AMC_ST_IDLE);
   end

   // ***********************************************
   // registers
   // ***********************************************
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         state_q              <= amc_pkg::AMC_ST_IDLE;
         cnt_q                <= `AMC_CNT_RST;
         csm_q                <= 1'b0;
         ready_o              <= 1'b0;
         rvalid_o             <= 1'b0;
         rdata_o              <= `AMC_DATA_RST;
         wdone_o              <= 1'b0;
         mem_addr_o           <= `AMC_ADDR_RST;
         mem_ce_n_o           <= 1'b1;
         mem_we_n_o           <= 1'b1;
         mem_oe_n_o           <= 1'b1;
         byte_lane_select_n_o <= `AMC_BLS_IDLE;
         mem_dq_o             <= `AMC_DATA_RST;
         mem_dq_oe_o          <= 1'b0;
      end
      else
      begin
         state_q              <= state_d;
         cnt_q                <= cnt_d;
         csm_q                <= csm_d;
         ready_o              <= ready_d;
         rvalid_o             <= rvalid_d;
         rdata_o              <= rdata_d;
         wdone_o              <= wdone_d;
         mem_addr_o           <= addr_d;
         mem_ce_n_o           <= ce_n_d;
         mem_we_n_o           <= we_n_d;
         mem_oe_n_o           <= oe_n_d;
         byte_lane_select_n_o <= bls_d;
         mem_dq_o             <= dq_d;
         mem_dq_oe_o          <= dq_oe_d;
      end
   end

endmodule

`default_nettype wire

// *** rtl/amc_params.svh ***
`ifndef AMC_PARAMS_SVH
`define AMC_PARAMS_SVH

// ***********************************************
// bus widths and idle levels
// ***********************************************
`define AMC_AW          16
`define AMC_DW          16
`define AMC_BW          2
`define AMC_CW          4
`define AMC_ADDR_RST    16'h0000
`define AMC_DATA_RST    16'h0000
`define AMC_BLS_IDLE    2'h3
`define AMC_CNT_RST     4'h0
`define AMC_CNT_ONE     4'h1
`define AMC_SYNC_STAGES 2

// ***********************************************
// timing figures in ns and derived cycle counts
// ***********************************************
`define AMC_CLK_NS      25
`define AMC_T_RC_NS     35
`define AMC_T_ACC_NS    35
`define AMC_T_WP_NS     20
`define AMC_T_WR_NS     12
`define AMC_T_HZ_NS     15
`define AMC_CEIL(t)     (((t) + `AMC_CLK_NS - 1) / `AMC_CLK_NS)
`define AMC_RD_CYC      `AMC_CEIL(`AMC_T_ACC_NS)
`define AMC_WP_CYC      `AMC_CEIL(`AMC_T_WP_NS)
`define AMC_WR_CYC      `AMC_CEIL(`AMC_T_WR_NS)
`define AMC_HZ_CYC      `AMC_CEIL(`AMC_T_HZ_NS)
`define AMC_RC_CYC      `AMC_CEIL(`AMC_T_RC_NS)

`endif

// *** rtl/amc_pkg.sv ***
`default_nettype none

package amc_pkg;

   // ***********************************************
   // controller states
   // ***********************************************
   typedef enum logic [2:0]
   {
      AMC_ST_IDLE   = 3'h0,
      AMC_ST_SETUP  = 3'h1,
      AMC_ST_STROBE = 3'h3,
      AMC_ST_RECOV  = 3'h2,
      AMC_ST_RACC   = 3'h4,
      AMC_ST_GAP    = 3'h5
   } amc_state_t;

endpackage

`default_nettype wire

// *** rtl/amc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "amc_params.svh"

module amc_sync
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   input  wire logic [`AMC_DW-1:0]   d_i,
   output var  logic [`AMC_DW-1:0]   q_o
);

   logic [`AMC_DW-1:0] meta_q;

   // ***********************************************
   // two stage pin synchroniser
   // ***********************************************
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         meta_q <= `AMC_DATA_RST;
         q_o    <= `AMC_DATA_RST;
      end
      else
      begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end

endmodule

`default_nettype wire

// *** verif/amc_chk_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "amc_params.svh"
// ******
// pin relations
// ******
module amc_chk
(
   input wire logic                 clk_i,
   input wire logic                 rst_b_i,
   input wire logic                 req_i,
   input wire logic                 we_i,
   input wire logic                 ready_o,
   input wire logic                 rvalid_o,
   input wire logic                 wdone_o,
   input wire logic [`AMC_AW-1:0]   mem_addr_o,
   input wire logic                 mem_ce_n_o,
   input wire logic                 mem_we_n_o,
   input wire logic                 mem_oe_n_o,
   input wire logic [`AMC_BW-1:0]   byte_lane_select_n_o,
   input wire logic                 mem_dq_oe_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   property p_rd_we;
      !mem_oe_n_o |-> mem_we_n_o;
   endproperty
   a_rd_we: assert property (p_rd_we) else $error("strobe low in read");
   property p_oe_wr;
      !mem_we_n_o |-> mem_oe_n_o && mem_dq_oe_o;
   endproperty
   a_oe_wr: assert property (p_oe_wr) else $error("oe or data bad in write");
   property p_a_rd;
      $fell(mem_ce_n_o) && !mem_oe_n_o |=> $stable(mem_addr_o);
   endproperty
   a_a_rd: assert property (p_a_rd) else $error("read address moved");
   property p_a_wr;
      !mem_we_n_o && !mem_ce_n_o |=> $stable(mem_addr_o) [*2];
   endproperty
   a_a_wr: assert property (p_a_wr) else $error("write address moved");
   property p_rd_lat;
      req_i && ready_o && !we_i |-> ##[5:6] rvalid_o;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_wr_lat;
      req_i && ready_o && we_i |-> ##[3:4] wdone_o;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
   property p_ce_gap;
      $fell(mem_ce_n_o) |=> !$fell(mem_ce_n_o) [*2];
   endproperty
   a_ce_gap: assert property (p_ce_gap) else $error("select falls too close");
   property p_bls;
      mem_ce_n_o && mem_we_n_o |-> byte_lane_select_n_o == `AMC_BLS_IDLE;
   endproperty
   a_bls: assert property (p_bls) else $error("byte select left low");
endmodule
bind amc_ctrl amc_chk amc_chk_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i),
   .we_i(we_i), .ready_o(ready_o), .rvalid_o(rvalid_o), .wdone_o(wdone_o),
   .mem_addr_o(mem_addr_o), .mem_ce_n_o(mem_ce_n_o), .mem_we_n_o(mem_we_n_o),
   .mem_oe_n_o(mem_oe_n_o), .byte_lane_select_n_o(byte_lane_select_n_o),
   .mem_dq_oe_o(mem_dq_oe_o));
`default_nettype wire

// *** verif/amc_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ******
// memory far side
// ******
module amc_mem_model
(
   input  wire logic [15:0]   addr_i,
   input  wire logic          ce_n_i,
   input  wire logic          we_n_i,
   input  wire logic          oe_n_i,
   input  wire logic [1:0]    bls_n_i,
   input  wire logic [15:0]   dq_i,
   output var  logic [15:0]   q_o
);
   logic [15:0] mem [0:65535];
   logic [15:0] last_q = 16'h0000;
   logic        rd;
   assign rd = !ce_n_i && !oe_n_i && we_n_i;
   always @(posedge we_n_i or posedge ce_n_i)
      if (!ce_n_i || !we_n_i)
         for (int b = 0; b < 2; b++)
            if (!bls_n_i[b])
               mem[addr_i][b*8+:8] = dq_i[b*8+:8];
   always @*
      for (int b = 0; b < 2; b++)
         q_o[b*8+:8] = (rd && !bls_n_i[b]) ? mem[addr_i][b*8+:8] : ~last_q[b*8+:8];
   // last shown byte, taken from the array so no loop runs through q_o
   always @*
      for (int b = 0; b < 2; b++)
         if (rd && !bls_n_i[b])
            last_q[b*8+:8] = mem[addr_i][b*8+:8];
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ******
// bench
// ******
module tb_top;
   logic        clk_i = 0, rst_b_i = 0, req_i = 0, we_i = 0, cs_ctrl_i = 0, w;
   logic [15:0] addr_i = 0, wdata_i = 0, rdata_o, mem_addr_o, mem_dq_o, mdl_q, dq_w;
   logic [15:0] exp_m [0:65535];
   logic [15:0] pool [0:3] = '{16'h0000, 16'hFFFF, 16'h5A5A, 16'h0001};
   logic [1:0]  be_i = 0, bls_n;
   logic        ready_o, rvalid_o, wdone_o, ce_n, we_n, oe_n, dq_oe;
   int          num_errors = 0, compares = 0, n;
   assign dq_w = dq_oe ? mem_dq_o : mdl_q;
   amc_ctrl amc_ctrl_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .we_i(we_i),
      .cs_ctrl_i(cs_ctrl_i), .addr_i(addr_i), .wdata_i(wdata_i), .be_i(be_i),
      .ready_o(ready_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o), .wdone_o(wdone_o),
      .mem_addr_o(mem_addr_o), .mem_ce_n_o(ce_n), .mem_we_n_o(we_n), .mem_oe_n_o(oe_n),
      .byte_lane_select_n_o(bls_n), .mem_dq_o(mem_dq_o), .mem_dq_oe_o(dq_oe),
      .mem_dq_i(dq_w));
   amc_mem_model amc_mem_model_i (.addr_i(mem_addr_o), .ce_n_i(ce_n), .we_n_i(we_n),
      .oe_n_i(oe_n), .bls_n_i(bls_n), .dq_i(dq_w), .q_o(mdl_q));
   initial forever #12.5 clk_i = ~clk_i;
   function logic [15:0] mask(input logic [1:0] b);
      return {{8{b[1]}}, {8{b[0]}}};
   endfunction
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] ev);
      compares++;
      if (seen !== ev)
      begin
         num_errors++;
         $display("BAD %s exp %h seen %h", nm, ev, seen);
      end
   endtask
   task wrap_up;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task do_op(input logic wr, cs, input logic [15:0] a, d, input logic [1:0] b);
      logic r;
      @(negedge clk_i);
      req_i = 1;
      {we_i, cs_ctrl_i, addr_i, wdata_i, be_i} = {wr, cs, a, d, b};
      n = 0;
      do
      begin
         r = ready_o;
         @(negedge clk_i);
         n++;
      end while (r !== 1'b1 && n < 20);
      req_i = 0;
      n = 0;
      while ((wr ? wdone_o : rvalid_o) !== 1'b1 && n < 20)
      begin
         @(negedge clk_i);
         n++;
      end
      chk("done", (n < 20) ? 16'h1 : 16'h0, 16'h1);
      if (wr)
         exp_m[a] = (exp_m[a] & ~mask(b)) | (d & mask(b));
      else
         chk("rdata", rdata_o & mask(b), exp_m[a] & mask(b));
   endtask
   initial
   begin
      repeat (5000) @(posedge clk_i);
      num_errors++;
      wrap_up();
   end
   initial
   begin
      void'($urandom(98729));
      repeat (20) @(negedge clk_i);
      chk("we_n", {15'h0, we_n}, 16'h1);
      chk("ready", {15'h0, ready_o}, 16'h0);
      rst_b_i = 1;
      @(negedge clk_i);
      chk("ready", {15'h0, ready_o}, 16'h1);
      foreach (pool[i])
         do_op(1, i[0], pool[i], 16'hA5C3 ^ pool[i], 2'h3);
      repeat (40)
      begin
         w = 1'($urandom_range(0, 1));
         do_op(w, 1'($urandom_range(0, 1)), pool[$urandom_range(0, 3)], 16'($urandom),
            2'($urandom_range(1, 3)));
      end
      do_op(1, 0, 16'hFFFF, 16'h1234, 2'h1);
      do_op(1, 1, 16'hFFFF, 16'hABCD, 2'h2);
      @(negedge clk_i);
      rst_b_i = 0;
      repeat (2) @(negedge clk_i);
      chk("ready", {15'h0, ready_o}, 16'h0);
      rst_b_i = 1;
      @(negedge clk_i);
      chk("ready", {15'h0, ready_o}, 16'h1);
      do_op(0, 0, 16'hFFFF, 16'h0000, 2'h3);
      wrap_up();
   end
endmodule
`default_nettype wire
